/* hdl/sink_port_regs.vh */
// constants for the sink port status output block
`ifndef SINK_PORT_REGS_VH
`define SINK_PORT_REGS_VH
`define LEVEL_W 3
`define LEVEL_MAX 3'h5
`define FINE_MAX 3'h4
`define SETTLE_NS 1000
`define CLK_NS 50
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`define SETTLE_W 5
`define VOLT_5V 3'h0
`define RES_IDLE 2'h0
`define RES_MATCH 2'h1
`define RES_FALLBACK 2'h2
`define RES_MISMATCH 2'h3
`endif

/* hdl/sink_port_status_outputs.v */
// strap sampling, gate enables, fault, orientation and host pin drivers of a sink port
//
// Contract
// - main gate only after a contract inside the strap voltage range
// - fallback gate when negotiation fails and the contract falls back to 5 V
// - host interrupt is active low, open drain, pull low only
// - fault high on unmet supply, overvoltage, overcurrent, enabled over-temperature; else low
// - over-temperature counts toward fault only when enabled by configuration
// - fault drives open-drain low with pull-up, push-pull with weak pull-down
// - charging strap pulled up selects battery-charging only; floating enables all
// - data-mode strap sampled once after power-up: pull-up power only, open data
// - open data-mode strap turns the pin into the orientation output after sampling
// - orientation low when unattached or on CC1, high when on CC2
// - configuration writes over I2C are retained in nonvolatile storage; this block holds no configuration storage
// - host interface is an I2C target with open-drain low-only pins
// - voltage straps give requested range; current straps give requested current
// - fault holds its level during renegotiation until outcome is known; overvoltage, overcurrent and enabled over-temperature still set it
// - min strap above max strap uses max as both bounds
`timescale 1ns/1ns
`default_nettype none
`include "sink_port_regs.vh"
module sink_port_status_outputs (
	input wire ref_clk_i,
	input wire reset_i,
	input wire [2:0] min_voltage_strap_i,
	input wire [2:0] max_voltage_strap_i,
	input wire [2:0] coarse_current_strap_i,
	input wire [2:0] fine_current_strap_i,
	input wire charging_mode_strap_i,
	input wire data_mode_orientation_i,
	input wire fault_pullup_sense_i,
	input wire [1:0] contract_result_i,
	input wire [2:0] contract_voltage_i,
	input wire contract_busy_i,
	input wire cc2_attached_i,
	input wire attached_i,
	input wire overvoltage_i,
	input wire overcurrent_i,
	input wire overtemp_i,
	input wire overtemp_enable_i,
	input wire main_path_host_enable_i,
	input wire host_event_i,
	input wire host_i2c_data_i,
	input wire host_i2c_data_drive_low_i,
	input wire host_i2c_clock_i,
	input wire host_i2c_clock_drive_low_i,
	output wire host_i2c_data_o,
	output wire host_i2c_data_oe_o,
	output wire host_i2c_clock_o,
	output wire host_i2c_clock_oe_o,
	output wire host_i2c_data_sync_o,
	output wire host_i2c_clock_sync_o,
	output reg main_path_gate_drive_o,
	output reg fallback_path_gate_enable_o,
	output wire host_interrupt_n_o,
	output wire host_interrupt_n_oe_o,
	output reg fault_o,
	output wire fault_oe_o,
	output reg data_mode_orientation_o,
	output wire data_mode_orientation_oe_o,
	output reg [2:0] req_min_voltage_o,
	output reg [2:0] req_max_voltage_o,
	output reg [2:0] req_coarse_current_o,
	output reg [2:0] req_fine_current_o,
	output reg bc_only_o,
	output reg power_only_o,
	output reg straps_valid_o
);

	// levels above the decoded range clamp to the top setting
	function [2:0] clamp_level;
		input [2:0] v;
		input [2:0] lim;
		begin
			clamp_level = (v > lim) ? lim : v;
		end
	endfunction

	// one place decodes the adapter outcome code
	function result_is;
		input [1:0] r;
		input [1:0] code;
		begin
			result_is = (r == code);
		end
	endfunction

	// two-flop synchronisers for all pins; the first stage is read by nothing else
	reg [16:0] pin_s1_r;
	reg [16:0] pin_s2_r;
	wire [16:0] pin_raw;
	assign pin_raw = {host_i2c_clock_i, host_i2c_data_i, data_mode_orientation_i,
		charging_mode_strap_i, fault_pullup_sense_i, fine_current_strap_i,
		coarse_current_strap_i, max_voltage_strap_i, min_voltage_strap_i};
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_s1_r <= 17'h00000;
			pin_s2_r <= 17'h00000;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end
	wire [2:0] s_min = pin_s2_r[2:0];
	wire [2:0] s_max = pin_s2_r[5:3];
	wire [2:0] s_coarse = pin_s2_r[8:6];
	wire [2:0] s_fine = pin_s2_r[11:9];
	wire s_pullup = pin_s2_r[12];
	wire s_charging = pin_s2_r[13];
	wire s_datamode = pin_s2_r[14];
	assign host_i2c_data_sync_o = pin_s2_r[15];
	assign host_i2c_clock_sync_o = pin_s2_r[16];

	// straps settle a short while after reset before the one capture
	reg [`SETTLE_W-1:0] settle_r;
	reg pullup_mode_r;
	// capture edge: the counter has run through the whole settle time
	wire settle_done = (settle_r == `SETTLE_CYC - 1);
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			settle_r <= `SETTLE_W'h00;
			straps_valid_o <= 1'b0;
			req_min_voltage_o <= 3'h0;
			req_max_voltage_o <= 3'h0;
			req_coarse_current_o <= 3'h0;
			req_fine_current_o <= 3'h0;
			bc_only_o <= 1'b0;
			power_only_o <= 1'b0;
			pullup_mode_r <= 1'b0;
		end else if (!straps_valid_o) begin
			if (!settle_done) begin
				settle_r <= settle_r + `SETTLE_W'h01;
			end else begin
				straps_valid_o <= 1'b1;
				req_max_voltage_o <= clamp_level(s_max, `LEVEL_MAX);
				if (s_min > s_max) begin
					req_min_voltage_o <= clamp_level(s_max, `LEVEL_MAX);
				end else begin
					req_min_voltage_o <= clamp_level(s_min, `LEVEL_MAX);
				end
				req_coarse_current_o <= clamp_level(s_coarse, `LEVEL_MAX);
				req_fine_current_o <= clamp_level(s_fine, `FINE_MAX);
				bc_only_o <= s_charging;
				power_only_o <= s_datamode;
				pullup_mode_r <= s_pullup;
			end
		end
	end

	wire in_range = (contract_voltage_i >= req_min_voltage_o) &&
		(contract_voltage_i <= req_max_voltage_o);
	wire hard_fault = overvoltage_i | overcurrent_i;
	wire temp_fault = overtemp_i & overtemp_enable_i;
	// a failed negotiation is only a fault when 5 V was not acceptable
	wire match_res = result_is(contract_result_i, `RES_MATCH);
	wire fallback_res = result_is(contract_result_i, `RES_FALLBACK);
	wire mismatch_res = result_is(contract_result_i, `RES_MISMATCH);
	wire fb_fault = fallback_res && (req_min_voltage_o != `VOLT_5V);
	wire supply_fault = mismatch_res || fb_fault || (match_res && !in_range);

	// next values; protection faults bypass the renegotiation hold
	reg fault_nxt;
	reg main_gate_nxt;
	reg fallback_gate_nxt;
	always @* begin
		fault_nxt = fault_o;
		if (hard_fault || temp_fault) begin
			fault_nxt = 1'b1;
		end else if (!contract_busy_i) begin
			fault_nxt = straps_valid_o & supply_fault;
		end
		main_gate_nxt = 1'b0;
		if (straps_valid_o && !contract_busy_i && match_res) begin
			// overvoltage, overcurrent and the host permit each veto the main path; over-temperature does not
			main_gate_nxt = in_range && !hard_fault && main_path_host_enable_i;
		end
		fallback_gate_nxt = 1'b0;
		if (straps_valid_o && !contract_busy_i && fallback_res) begin
			// no fallback path when the 5 V bus itself is overvoltage
			fallback_gate_nxt = !overvoltage_i;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			fault_o <= 1'b0;
			main_path_gate_drive_o <= 1'b0;
			fallback_path_gate_enable_o <= 1'b0;
		end else begin
			fault_o <= fault_nxt;
			main_path_gate_drive_o <= main_gate_nxt;
			fallback_path_gate_enable_o <= fallback_gate_nxt;
		end
	end

	// fault pin: push-pull when pulled down, else only drive low
	assign fault_oe_o = pullup_mode_r ? !fault_o : 1'b1;

	// orientation output only once sampling found the strap open
	// registered so the pin does not glitch while attach status settles
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			data_mode_orientation_o <= 1'b0;
		end else begin
			data_mode_orientation_o <= attached_i & cc2_attached_i;
		end
	end
	assign data_mode_orientation_oe_o = straps_valid_o & !power_only_o;

	assign host_interrupt_n_o = 1'b0;
	assign host_interrupt_n_oe_o = host_event_i;
	// i2c pins only ever pull low; the drive-low requests come from an engine outside this block
	assign host_i2c_data_o = 1'b0;
	assign host_i2c_data_oe_o = host_i2c_data_drive_low_i;
	assign host_i2c_clock_o = 1'b0;
	assign host_i2c_clock_oe_o = host_i2c_clock_drive_low_i;

endmodule // sink_port_status_outputs
`default_nettype wire

/* verif/sink_port_chk.sv */
// assertion checker for the sink port status outputs
`timescale 1ns/1ns
`default_nettype none
`include "sink_port_regs.vh"
module sink_port_chk (
	input wire logic ref_clk_i, reset_i, overvoltage_i, overcurrent_i, overtemp_i,
	input wire logic overtemp_enable_i, contract_busy_i, host_event_i, fault_pullup_sense_i,
	input wire logic [1:0] contract_result_i,
	input wire logic [2:0] contract_voltage_i,
	input wire logic main_path_gate_drive_o, fallback_path_gate_enable_o, fault_o, fault_oe_o,
	input wire logic host_interrupt_n_o, host_interrupt_n_oe_o, straps_valid_o,
	input wire logic [2:0] req_min_voltage_o, req_max_voltage_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	wire ovoc = overvoltage_i | overcurrent_i;
	wire in_rng = contract_voltage_i >= req_min_voltage_o && contract_voltage_i <= req_max_voltage_o;
	// the drive mode is a strap: it follows the pin only until the capture
	logic pullup_r;
	always @(posedge ref_clk_i) begin
		if (reset_i) pullup_r <= 1'b0;
		else if (!straps_valid_o) pullup_r <= fault_pullup_sense_i;
	end
	gate_off_fault_a: assert property (ovoc |=> !main_path_gate_drive_o)
		else $error("main gate on during fault");
	fault_set_a: assert property (ovoc |=> fault_o) else $error("fault not raised");
	temp_mask_a: assert property (overtemp_i && !overtemp_enable_i && !ovoc && !contract_busy_i
		&& contract_result_i == `RES_MATCH && in_rng |=> !fault_o)
		else $error("masked temp raised fault");
	fault_hold_a: assert property (contract_busy_i && !ovoc && !(overtemp_i && overtemp_enable_i)
		|=> fault_o == $past(fault_o)) else $error("fault moved in renegotiation");
	busy_gate_a: assert property (contract_busy_i |=> !main_path_gate_drive_o)
		else $error("main gate on while busy");
	main_cause_a: assert property (main_path_gate_drive_o |-> $past(contract_result_i) == `RES_MATCH)
		else $error("main gate without match");
	fb_cause_a: assert property (fallback_path_gate_enable_o
		|-> $past(contract_result_i) == `RES_FALLBACK) else $error("fallback gate without fallback");
	int_drain_a: assert property (!host_interrupt_n_o && host_interrupt_n_oe_o == host_event_i)
		else $error("interrupt pin not open drain");
	fault_drive_a: assert property (straps_valid_o |-> fault_oe_o == (pullup_r ? !fault_o : 1'b1))
		else $error("fault drive mode wrong");
	strap_hold_a: assert property (straps_valid_o && $past(straps_valid_o)
		|-> $stable(req_max_voltage_o) && $stable(req_min_voltage_o)) else $error("strap value moved");
	range_order_a: assert property (straps_valid_o |-> req_min_voltage_o <= req_max_voltage_o)
		else $error("min above max");
	cover property ($rose(straps_valid_o));
	cover property (fallback_path_gate_enable_o);
	cover property (ovoc ##1 fault_o);
endmodule // sink_port_chk
bind sink_port_status_outputs sink_port_chk u_chk (.*);
`default_nettype wire

/* verif/adapter_model.sv */
// adapter side model: negotiates a contract against the requested voltage range
`timescale 1ns/1ns
`default_nettype none
`include "sink_port_regs.vh"
module adapter_model (
	input wire logic ref_clk_i, go_i,
	input wire logic [2:0] min_i, max_i, offer_i,
	output logic busy_o = 1'b0,
	output logic [1:0] result_o = `RES_IDLE,
	output logic [2:0] voltage_o = `VOLT_5V
);
	int n = 0;
	// the old contract is dropped at once, so a sink must not read idle as an outcome
	always @(posedge ref_clk_i) begin
		if (go_i && n == 0) begin
			n <= 4;
			busy_o <= 1'b1;
			result_o <= `RES_IDLE;
		end else if (n > 1) begin
			n <= n - 1;
		end else if (n == 1) begin
			n <= 0;
			busy_o <= 1'b0;
			result_o <= (offer_i >= min_i && offer_i <= max_i) ? `RES_MATCH : `RES_FALLBACK;
			voltage_o <= (offer_i >= min_i && offer_i <= max_i) ? offer_i : `VOLT_5V;
		end
	end
endmodule // adapter_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the sink port status outputs
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic ref_clk_i = 0, reset_i = 1, charging_mode_strap_i = 1, data_mode_orientation_i = 0;
	logic [2:0] min_voltage_strap_i = 3'h3, max_voltage_strap_i = 3'h1, offer = 3'h3;
	logic [2:0] coarse_current_strap_i = 3'h2, fine_current_strap_i = 3'h4;
	logic fault_pullup_sense_i = 1, cc2_attached_i = 0, attached_i = 0, overvoltage_i = 0, go = 0;
	logic overcurrent_i = 0, overtemp_i = 0, overtemp_enable_i = 0, main_path_host_enable_i = 1;
	logic host_event_i = 0, host_i2c_data_drive_low_i = 0, host_i2c_clock_drive_low_i = 0;
	wire contract_busy_i, host_i2c_data_o, host_i2c_data_oe_o, host_i2c_clock_o, host_i2c_clock_oe_o;
	wire [1:0] contract_result_i;
	wire [2:0] contract_voltage_i, req_min_voltage_o, req_max_voltage_o;
	wire [2:0] req_coarse_current_o, req_fine_current_o;
	wire host_i2c_data_sync_o, host_i2c_clock_sync_o, main_path_gate_drive_o, fault_o, fault_oe_o;
	wire fallback_path_gate_enable_o, host_interrupt_n_o, host_interrupt_n_oe_o, straps_valid_o;
	wire data_mode_orientation_o, data_mode_orientation_oe_o, bc_only_o, power_only_o;
	// pulled-up bus lines: low only while the block drives them
	wire host_i2c_data_i = !host_i2c_data_oe_o;
	wire host_i2c_clock_i = !host_i2c_clock_oe_o;
	int errors = 0, n_checks = 0;
	sink_port_status_outputs u_dut (.*);
	adapter_model u_adp (.ref_clk_i, .go_i(go), .min_i(req_min_voltage_o), .max_i(req_max_voltage_o),
		.offer_i(offer), .busy_o(contract_busy_i), .result_o(contract_result_i),
		.voltage_o(contract_voltage_i));
	always #25 ref_clk_i = ~ref_clk_i;
	task chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask
	task straps_scn;
		cyc(25);
		chk("valid", straps_valid_o, 1);
		chk("min", req_min_voltage_o, 1);
		chk("max", req_max_voltage_o, 1);
		chk("coarse", req_coarse_current_o, 2);
		chk("fine", req_fine_current_o, 4);
		chk("bc", bc_only_o, 1);
		chk("power", power_only_o, 0);
		max_voltage_strap_i = 3'h5;
		cyc(5);
		chk("held", req_max_voltage_o, 1);
	endtask
	task orient_scn;
		attached_i = 1;
		cc2_attached_i = 1;
		cyc(2);
		chk("flip", data_mode_orientation_o, 1);
		chk("flip oe", data_mode_orientation_oe_o, 1);
		cc2_attached_i = 0;
		cyc(2);
		chk("unflip", data_mode_orientation_o, 0);
	endtask
	task contract_scn;
		go = 1;
		cyc(1);
		go = 0;
		cyc(8);
		chk("fallback", fallback_path_gate_enable_o, 1);
		chk("fb fault", fault_o, 1);
		offer = 3'h1;
		go = 1;
		cyc(1);
		go = 0;
		cyc(2);
		chk("fault held", fault_o, 1);
		chk("busy gate", main_path_gate_drive_o, 0);
		cyc(6);
		chk("main", main_path_gate_drive_o, 1);
		chk("fault clear", fault_o, 0);
	endtask
	task fault_scn;
		overcurrent_i = 1;
		cyc(1);
		chk("oc fault", fault_o, 1);
		chk("oc gate", main_path_gate_drive_o, 0);
		overcurrent_i = 0;
		overtemp_i = 1;
		cyc(2);
		chk("temp masked", fault_o, 0);
		chk("drain low idle", fault_oe_o, 1);
		overtemp_enable_i = 1;
		cyc(1);
		chk("temp fault", fault_o, 1);
		chk("open drain", fault_oe_o, 0);
		chk("sda idle", host_i2c_data_sync_o, 1);
		host_event_i = 1;
		// the host engine pulls both lines, as during a firmware transfer
		host_i2c_data_drive_low_i = 1;
		host_i2c_clock_drive_low_i = 1;
		cyc(3);
		chk("int", {host_interrupt_n_oe_o, host_interrupt_n_o}, 2);
		chk("sda", host_i2c_data_sync_o, 0);
		chk("scl", {host_i2c_clock_oe_o, host_i2c_clock_o, host_i2c_clock_sync_o}, 4);
	endtask
	initial begin
		cyc(16);
		reset_i = 0;
		straps_scn;
		orient_scn;
		contract_scn;
		fault_scn;
		tally_and_finish;
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
